//--- common/tdw_pkg.sv
// Package: constants, field layouts and carrier types for the tile debug/config register block
package tdw_pkg;

  // Register numbers, processor status (debug) space
  localparam logic [7:0] TDW_DW_ADDR1_BASE = 8'h50;
  localparam logic [7:0] TDW_DW_ADDR2_BASE = 8'h60;
  localparam logic [7:0] TDW_DW_CTRL_BASE  = 8'h70;
  localparam logic [7:0] TDW_RW_MASK_BASE  = 8'h80;
  localparam logic [7:0] TDW_RW_VALUE_BASE = 8'h90;
  localparam logic [7:0] TDW_RW_CTRL_BASE  = 8'h9C;
  localparam logic [7:0] TDW_SCRATCH_BASE  = 8'h20;

  // Register numbers, tile configuration space
  localparam logic [7:0] TDW_TILE_ID       = 8'h00;
  localparam logic [7:0] TDW_TILE_DESC1    = 8'h01;
  localparam logic [7:0] TDW_TILE_DESC2    = 8'h02;
  localparam logic [7:0] TDW_DBG_PERM      = 8'h04;
  localparam logic [7:0] TDW_DBG_IRQ       = 8'h05;
  localparam logic [7:0] TDW_CLK_DIV       = 8'h06;
  localparam logic [7:0] TDW_SEC_COPY      = 8'h07;

  // Field positions
  localparam int TDW_THR_EN_LSB   = 16;
  localparam int TDW_CTL_EN_BIT   = 0;
  localparam int TDW_CTL_MODE_BIT = 1;
  localparam int TDW_CTL_LOAD_BIT = 2;
  localparam int TDW_IRQ_REQ_BIT  = 0;
  localparam int TDW_IRQ_DBGM_BIT = 1;
  localparam int TDW_CLK_OFF_BIT  = 31;
  localparam int TDW_SEC_TAP_BIT  = 0;
  localparam int TDW_SEC_PLL_BIT  = 4;
  localparam int TDW_SEC_BOOT_BIT = 5;
  localparam int TDW_SEC_RED_BIT  = 7;
  localparam int TDW_SEC_LCK_LSB  = 8;
  localparam int TDW_SEC_LALL_BIT = 12;
  localparam int TDW_SEC_GDBG_BIT = 14;
  localparam int TDW_SEC_WP_BIT   = 31;

  // Writable-bit masks, and the defined-bit mask of the OTP-loaded security word; everything else reads zero
  localparam logic [31:0] TDW_DW_CTRL_WMASK = 32'h00FF0007;
  localparam logic [31:0] TDW_RW_CTRL_WMASK = 32'h00FF0003;
  localparam logic [31:0] TDW_PERM_WMASK    = 32'h00000001;
  localparam logic [31:0] TDW_CLKDIV_WMASK  = 32'h8000FFFF;
  localparam logic [31:0] TDW_SEC_MASK      = 32'h80005FB1;

  // Reset values
  localparam logic [31:0] TDW_CTRL_RST = 32'h00000000;
  localparam logic [31:0] TDW_WORD_RST = 32'h00000000;

  // Debug interrupt cause codes
  localparam logic [2:0] TDW_CAUSE_DATA = 3'h4;
  localparam logic [2:0] TDW_CAUSE_RES  = 3'h5;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        tile_space;
    logic [7:0]  num;
    logic [31:0] wdata;
  } tdw_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic        load;
    logic [2:0]  thread;
    logic [31:0] addr;
  } tdw_mem_op_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic [31:0] res_id;
  } tdw_res_op_t;

  typedef struct packed {
    logic [2:0]  cause;
    logic [1:0]  watch_num;
    logic [2:0]  thread;
    logic [31:0] data;
  } tdw_dbg_event_t;

endpackage : tdw_pkg

//--- design/tdw_regs.sv
// Tile debug watchpoint and tile configuration register block
`timescale 1ns/1ps
module tdw_regs
  import tdw_pkg::*;
#(
  parameter int          NUM_WATCH  = 4,
  parameter logic [31:0] TILE_ID    = 32'h0000A5A5, // Arbitrary identification value
  parameter logic [7:0]  NUM_CHANEND = 8'h20,
  parameter logic [7:0]  NUM_LOCK    = 8'h04,
  parameter logic [7:0]  NUM_SYNC    = 8'h07,
  parameter logic [7:0]  NUM_CLKBLK  = 8'h06,
  parameter logic [7:0]  NUM_TIMER   = 8'h0A
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  tdw_cfg_req_t        cfg_req,
  input  tdw_mem_op_t         mem_op,
  input  tdw_res_op_t         res_op,
  input  wire logic           in_debug_mode,
  input  wire logic           otp_sec_load,
  input  wire logic [31:0]    otp_sec_word,
  output logic                cfg_ack_r,
  output logic                cfg_err_r,
  output logic [31:0]         cfg_rdata_r,
  output logic                dbg_irq_r,
  output tdw_dbg_event_t      dbg_event_r,
  output logic                tile_tick_r,
  output logic                tap_deny_r,
  output logic                pll_boot_deny_r,
  output logic                boot_from_otp_r,
  output logic                otp_redundant_r,
  output logic [3:0]          otp_sector_lock_r,
  output logic                global_debug_deny_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0] dw_addr1_r [NUM_WATCH];
  logic [31:0] dw_addr2_r [NUM_WATCH];
  logic [31:0] dw_ctrl_r  [NUM_WATCH];
  logic [31:0] rw_mask_r  [NUM_WATCH];
  logic [31:0] rw_value_r [NUM_WATCH];
  logic [31:0] rw_ctrl_r  [NUM_WATCH];
  logic [31:0] scratch_r  [8];
  logic        perm_block_r;
  logic        irq_req_r;
  logic [31:0] clk_div_r;
  logic [31:0] sec_word_r;
  logic [15:0] div_cnt_r;

  // Keeps only the writable bits of a written word
  function automatic logic [31:0] wr_masked(input logic [31:0] d, input logic [31:0] m);
    return d & m;
  endfunction : wr_masked

  // True if the number hits a register within a block of four
  function automatic logic in_block(input logic [7:0] num, input logic [7:0] base);
    return (num >= base) && (num < base + 8'h04);
  endfunction : in_block

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  logic       wr_dbg;
  logic       wr_tile;
  logic [1:0] widx;
  logic       tile_dbg_target;
  logic       tile_wr_ok;

  assign wr_dbg  = cfg_req.valid && cfg_req.write && !cfg_req.tile_space;
  assign wr_tile = cfg_req.valid && cfg_req.write && cfg_req.tile_space;
  assign widx    = cfg_req.num[1:0];
  // Debug-facing tile registers; the permission register stays writable so it can be undone
  assign tile_dbg_target = (cfg_req.num == TDW_DBG_IRQ) || (cfg_req.num == TDW_CLK_DIV) ||
                           (cfg_req.num[7:3] == TDW_SCRATCH_BASE[7:3]);
  assign tile_wr_ok = wr_tile && !(perm_block_r && tile_dbg_target);

  ////////////////////////////////////////////////////////////////////////////
  // Watchpoint registers
  // address, mask, value writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_WATCH; i++) begin
        dw_addr1_r[i] <= TDW_WORD_RST;
        dw_addr2_r[i] <= TDW_WORD_RST;
        rw_mask_r[i]  <= TDW_WORD_RST;
        rw_value_r[i] <= TDW_WORD_RST;
      end
    end else if (wr_dbg) begin
      if (in_block(cfg_req.num, TDW_DW_ADDR1_BASE)) begin
        dw_addr1_r[widx] <= cfg_req.wdata;
      end
      if (in_block(cfg_req.num, TDW_DW_ADDR2_BASE)) begin
        dw_addr2_r[widx] <= cfg_req.wdata;
      end
      if (in_block(cfg_req.num, TDW_RW_MASK_BASE)) begin
        rw_mask_r[widx] <= cfg_req.wdata;
      end
      if (in_block(cfg_req.num, TDW_RW_VALUE_BASE)) begin
        rw_value_r[widx] <= cfg_req.wdata;
      end
    end
  end

  // control writes keep only defined bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_WATCH; i++) begin
        dw_ctrl_r[i] <= TDW_CTRL_RST;
        rw_ctrl_r[i] <= TDW_CTRL_RST;
      end
    end else if (wr_dbg) begin
      if (in_block(cfg_req.num, TDW_DW_CTRL_BASE)) begin
        dw_ctrl_r[widx] <= wr_masked(cfg_req.wdata, TDW_DW_CTRL_WMASK);
      end
      if (in_block(cfg_req.num, TDW_RW_CTRL_BASE)) begin
        rw_ctrl_r[widx] <= wr_masked(cfg_req.wdata, TDW_RW_CTRL_WMASK);
      end
    end
  end

  // Scratch set is shared by both spaces
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        scratch_r[i] <= TDW_WORD_RST;
      end
    end else if ((wr_dbg || tile_wr_ok) && cfg_req.num[7:3] == TDW_SCRATCH_BASE[7:3]) begin
      scratch_r[cfg_req.num[2:0]] <= cfg_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tile configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      perm_block_r <= 1'b0;
    end else if (wr_tile && cfg_req.num == TDW_DBG_PERM) begin
      perm_block_r <= cfg_req.wdata[0];
    end
  end

  // request sticks until the core reaches debug mode; a new write wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_req_r <= 1'b0;
    end else if (tile_wr_ok && cfg_req.num == TDW_DBG_IRQ && cfg_req.wdata[TDW_IRQ_REQ_BIT]) begin
      irq_req_r <= 1'b1;
    end else if (in_debug_mode) begin
      irq_req_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_div_r <= TDW_WORD_RST;
    end else if (tile_wr_ok && cfg_req.num == TDW_CLK_DIV) begin
      clk_div_r <= wr_masked(cfg_req.wdata, TDW_CLKDIV_WMASK);
    end
  end

  // loaded only from OTP; bus writes never reach it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_word_r <= TDW_WORD_RST;
    end else if (otp_sec_load) begin
      sec_word_r <= otp_sec_word & TDW_SEC_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tile clock tick: one pulse every divider+1 cycles
  // tick generation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_r   <= 16'h0000;
      tile_tick_r <= 1'b0;
    end else if (clk_div_r[TDW_CLK_OFF_BIT]) begin
      div_cnt_r   <= 16'h0000;
      tile_tick_r <= 1'b0;
    end else if (div_cnt_r >= clk_div_r[15:0]) begin
      div_cnt_r   <= 16'h0000;
      tile_tick_r <= 1'b1;
    end else begin
      div_cnt_r   <= div_cnt_r + 16'h0001;
      tile_tick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Security outputs
  // decoded security controls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tap_deny_r          <= 1'b0;
      pll_boot_deny_r     <= 1'b0;
      boot_from_otp_r     <= 1'b0;
      otp_redundant_r     <= 1'b0;
      otp_sector_lock_r   <= 4'h0;
      global_debug_deny_r <= 1'b0;
    end else begin
      tap_deny_r          <= sec_word_r[TDW_SEC_TAP_BIT];
      pll_boot_deny_r     <= sec_word_r[TDW_SEC_PLL_BIT];
      boot_from_otp_r     <= sec_word_r[TDW_SEC_BOOT_BIT];
      otp_redundant_r     <= sec_word_r[TDW_SEC_RED_BIT];
      otp_sector_lock_r   <= sec_word_r[TDW_SEC_LCK_LSB +: 4] |
                             {4{sec_word_r[TDW_SEC_LALL_BIT]}};
      global_debug_deny_r <= sec_word_r[TDW_SEC_GDBG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchpoint comparison
  logic [NUM_WATCH-1:0] dw_hit;
  logic [NUM_WATCH-1:0] rw_hit;

  always_comb begin
    logic ca;
    logic cb;
    ca = 1'b0;
    cb = 1'b0;
    for (int i = 0; i < NUM_WATCH; i++) begin
      // A: at or above first address, B: at or below second address
      ca = mem_op.addr >= dw_addr1_r[i];
      cb = mem_op.addr <= dw_addr2_r[i];
      dw_hit[i] = mem_op.valid && dw_ctrl_r[i][TDW_CTL_EN_BIT] &&
                  dw_ctrl_r[i][TDW_THR_EN_LSB + int'(mem_op.thread)] &&
                  (mem_op.load == dw_ctrl_r[i][TDW_CTL_LOAD_BIT]) &&
                  (dw_ctrl_r[i][TDW_CTL_MODE_BIT] ? (ca || cb) : (ca && cb));
      rw_hit[i] = res_op.valid && rw_ctrl_r[i][TDW_CTL_EN_BIT] &&
                  rw_ctrl_r[i][TDW_THR_EN_LSB + int'(res_op.thread)] &&
                  (((res_op.res_id & rw_mask_r[i]) == rw_value_r[i]) ^
                   rw_ctrl_r[i][TDW_CTL_MODE_BIT]);
    end
  end

  // Lowest numbered watchpoint wins
  function automatic logic [1:0] lowest(input logic [NUM_WATCH-1:0] v);
    logic [1:0] n;
    n = 2'h0;
    for (int i = NUM_WATCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = 2'(i);
      end
    end
    return n;
  endfunction : lowest

  // cause recording; data watch has priority over resource in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dbg_irq_r   <= 1'b0;
      dbg_event_r <= '0;
    end else if (|dw_hit) begin
      dbg_irq_r   <= 1'b1;
      dbg_event_r <= '{TDW_CAUSE_DATA, lowest(dw_hit), mem_op.thread, mem_op.addr};
    end else if (|rw_hit) begin
      dbg_irq_r   <= 1'b1;
      dbg_event_r <= '{TDW_CAUSE_RES, lowest(rw_hit), res_op.thread, res_op.res_id};
    end else begin
      dbg_irq_r   <= irq_req_r && !in_debug_mode;
      dbg_event_r <= dbg_event_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and answer
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (cfg_req.num[7:3] == TDW_SCRATCH_BASE[7:3]) begin
      rd_mux = scratch_r[cfg_req.num[2:0]];
    end else if (cfg_req.tile_space) begin
      unique case (cfg_req.num)
        TDW_TILE_ID:    rd_mux = TILE_ID;
        TDW_TILE_DESC1: rd_mux = {NUM_CHANEND, NUM_LOCK, NUM_SYNC, 8'h00};
        TDW_TILE_DESC2: rd_mux = {16'h0000, NUM_CLKBLK, NUM_TIMER};
        TDW_DBG_PERM:   rd_mux = {31'h00000000, perm_block_r} & TDW_PERM_WMASK;
        TDW_DBG_IRQ:    rd_mux = {30'h00000000, in_debug_mode, irq_req_r};
        TDW_CLK_DIV:    rd_mux = clk_div_r;
        TDW_SEC_COPY:   rd_mux = sec_word_r;
        default:        rd_hit = 1'b0;
      endcase
    end else if (in_block(cfg_req.num, TDW_DW_ADDR1_BASE)) begin
      rd_mux = dw_addr1_r[widx];
    end else if (in_block(cfg_req.num, TDW_DW_ADDR2_BASE)) begin
      rd_mux = dw_addr2_r[widx];
    end else if (in_block(cfg_req.num, TDW_DW_CTRL_BASE)) begin
      rd_mux = dw_ctrl_r[widx];
    end else if (in_block(cfg_req.num, TDW_RW_MASK_BASE)) begin
      rd_mux = rw_mask_r[widx];
    end else if (in_block(cfg_req.num, TDW_RW_VALUE_BASE)) begin
      rd_mux = rw_value_r[widx];
    end else if (in_block(cfg_req.num, TDW_RW_CTRL_BASE)) begin
      rd_mux = rw_ctrl_r[widx];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Errors flag unmapped numbers, blocked writes and writes to read-only registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ack_r   <= 1'b0;
      cfg_err_r   <= 1'b0;
      cfg_rdata_r <= 32'h00000000;
    end else begin
      cfg_ack_r   <= cfg_req.valid;
      cfg_err_r   <= cfg_req.valid && (!rd_hit || (wr_tile && !tile_wr_ok) ||
                     (wr_tile && cfg_req.num <= TDW_SEC_COPY &&
                      cfg_req.num != TDW_DBG_PERM && !tile_dbg_target));
      cfg_rdata_r <= (cfg_req.valid && !cfg_req.write) ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_ctrl_reserved: assert property (
    @(posedge clk) disable iff (!rstn)
    (dw_ctrl_r[0] & ~TDW_DW_CTRL_WMASK) == 32'h0 && (rw_ctrl_r[0] & ~TDW_RW_CTRL_WMASK) == 32'h0)
    else $error("reserved control bits set");
  chk_addr2_write: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_dbg && cfg_req.num == TDW_DW_ADDR2_BASE |=> dw_addr2_r[0] == $past(cfg_req.wdata))
    else $error("second address not stored");
  chk_perm_block: assert property (
    @(posedge clk) disable iff (!rstn)
    perm_block_r && wr_tile && cfg_req.num == TDW_CLK_DIV |=> $stable(clk_div_r))
    else $error("blocked write changed divider");
  chk_irq_request: assert property (
    @(posedge clk) disable iff (!rstn)
    tile_wr_ok && cfg_req.num == TDW_DBG_IRQ && cfg_req.wdata[0] |=> irq_req_r)
    else $error("debug request not raised");
  chk_tick_off: assert property (
    @(posedge clk) disable iff (!rstn)
    clk_div_r[TDW_CLK_OFF_BIT] |=> !tile_tick_r)
    else $error("tick while clock disabled");
  // Divider must hold across the whole period, else the period changes legally
  chk_tick_rate: assert property (
    @(posedge clk) disable iff (!rstn)
    tile_tick_r && clk_div_r == 32'h00000002 ##1 clk_div_r == 32'h00000002 ##1
    clk_div_r == 32'h00000002 |-> !tile_tick_r && !$past(tile_tick_r) ##1 tile_tick_r)
    else $error("tick period wrong");
  chk_sec_readonly: assert property (
    @(posedge clk) disable iff (!rstn)
    !otp_sec_load |=> $stable(sec_word_r))
    else $error("security word changed without OTP load");
  chk_data_cause: assert property (
    @(posedge clk) disable iff (!rstn)
    |dw_hit |=> dbg_irq_r && dbg_event_r.cause == TDW_CAUSE_DATA)
    else $error("data watch cause wrong");
  chk_res_cause: assert property (
    @(posedge clk) disable iff (!rstn)
    !(|dw_hit) && |rw_hit |=> dbg_irq_r && dbg_event_r.cause == TDW_CAUSE_RES)
    else $error("resource watch cause wrong");
  chk_thread_gate: assert property (
    @(posedge clk) disable iff (!rstn)
    |dw_hit && !wr_dbg |=> dw_ctrl_r[dbg_event_r.watch_num][TDW_CTL_EN_BIT] &&
      dw_ctrl_r[dbg_event_r.watch_num][TDW_THR_EN_LSB + int'(dbg_event_r.thread)])
    else $error("watch fired for disabled thread");
  chk_sector_all: assert property (
    @(posedge clk) disable iff (!rstn)
    sec_word_r[TDW_SEC_LALL_BIT] |=> otp_sector_lock_r == 4'hF)
    else $error("lock-all not applied");

endmodule : tdw_regs

//--- test/tb.sv
// Self-checking testbench for the tile debug and configuration register block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  $display("Error %s expected %h seen %h", nm, exp, got); n_mismatch++; end end

module tb;
  import tdw_pkg::*;
  logic           clk;
  logic           rstn;
  tdw_cfg_req_t   cfg_req;
  tdw_mem_op_t    mem_op;
  tdw_res_op_t    res_op;
  logic           in_debug_mode;
  logic           otp_sec_load;
  logic [31:0]    otp_sec_word;
  logic           cfg_ack_r;
  logic           cfg_err_r;
  logic [31:0]    cfg_rdata_r;
  logic           dbg_irq_r;
  tdw_dbg_event_t dbg_event_r;
  logic           tile_tick_r;
  logic           tap_deny_r;
  logic           pll_boot_deny_r;
  logic           boot_from_otp_r;
  logic           otp_redundant_r;
  logic [3:0]     otp_sector_lock_r;
  logic           global_debug_deny_r;
  int             n_mismatch = 0;
  int             cmp_count = 0;

  tdw_regs tdw_regs_inst (
    .clk(clk), .rstn(rstn), .cfg_req(cfg_req), .mem_op(mem_op), .res_op(res_op),
    .in_debug_mode(in_debug_mode), .otp_sec_load(otp_sec_load), .otp_sec_word(otp_sec_word),
    .cfg_ack_r(cfg_ack_r), .cfg_err_r(cfg_err_r), .cfg_rdata_r(cfg_rdata_r),
    .dbg_irq_r(dbg_irq_r), .dbg_event_r(dbg_event_r), .tile_tick_r(tile_tick_r),
    .tap_deny_r(tap_deny_r), .pll_boot_deny_r(pll_boot_deny_r),
    .boot_from_otp_r(boot_from_otp_r), .otp_redundant_r(otp_redundant_r),
    .otp_sector_lock_r(otp_sector_lock_r), .global_debug_deny_r(global_debug_deny_r)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // One config access; answer is looked at in the cycle after the request
  task automatic acc(input logic ts, input logic w, input logic [7:0] n, input logic [31:0] wd,
                     input logic [31:0] exp_rd, input logic exp_err);
    @(negedge clk);
    cfg_req = '{valid: 1'b1, write: w, tile_space: ts, num: n, wdata: wd};
    @(negedge clk);
    `CHK("ack", 1'b1, cfg_ack_r)
    `CHK("err", exp_err, cfg_err_r)
    `CHK("rdata", exp_rd, cfg_rdata_r)
    cfg_req.valid = 1'b0;
  endtask : acc

  task automatic wr(input logic ts, input logic [7:0] n, input logic [31:0] d, input logic e);
    acc(ts, 1'b1, n, d, 32'h00000000, e);
  endtask : wr

  task automatic rd(input logic ts, input logic [7:0] n, input logic [31:0] d, input logic e);
    acc(ts, 1'b0, n, 32'h00000000, d, e);
  endtask : rd

  // One watched operation, then check of the interrupt and recorded event
  task automatic op(input logic res, input logic ld, input logic [2:0] th, input logic [31:0] v,
                    input logic hit, input logic [2:0] cause, input logic [1:0] wn);
    @(negedge clk);
    if (res) begin
      res_op = '{valid: 1'b1, thread: th, res_id: v};
    end else begin
      mem_op = '{valid: 1'b1, load: ld, thread: th, addr: v};
    end
    @(negedge clk);
    mem_op.valid = 1'b0;
    res_op.valid = 1'b0;
    `CHK("irq", hit, dbg_irq_r)
    if (hit) begin
      `CHK("cause", cause, dbg_event_r.cause)
      `CHK("watch", wn, dbg_event_r.watch_num)
      `CHK("thread", th, dbg_event_r.thread)
      `CHK("data", v, dbg_event_r.data)
    end
  endtask : op

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(1'b1, 8'h05, 32'h00000000, 1'b0);
    rd(1'b1, 8'h06, 32'h00000000, 1'b0);
    rd(1'b0, 8'h70, 32'h00000000, 1'b0);
    rd(1'b0, 8'h9F, 32'h00000000, 1'b0);
    rd(1'b1, 8'h07, 32'h00000000, 1'b0);
  endtask : t_reset

  task automatic t_regs();
    logic [7:0] b[4];
    b = '{8'h50, 8'h60, 8'h80, 8'h90};
    // All written first, so aliasing between registers shows on read-back
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 4; i++) begin
        wr(1'b0, b[j] + 8'(i), {b[j], 16'hC3C3, 8'(i)}, 1'b0);
      end
    end
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 4; i++) begin
        rd(1'b0, b[j] + 8'(i), {b[j], 16'hC3C3, 8'(i)}, 1'b0);
      end
    end
    wr(1'b0, 8'h71, 32'hFFFFFFFF, 1'b0);
    rd(1'b0, 8'h71, 32'h00FF0007, 1'b0);
    wr(1'b0, 8'h9E, 32'hFFFFFFFF, 1'b0);
    rd(1'b0, 8'h9E, 32'h00FF0003, 1'b0);
    wr(1'b0, 8'h71, 32'h00000000, 1'b0);
    wr(1'b0, 8'h9E, 32'h00000000, 1'b0);
  endtask : t_regs

  task automatic t_desc();
    rd(1'b1, 8'h00, 32'h0000A5A5, 1'b0);
    rd(1'b1, 8'h01, 32'h20040700, 1'b0);
    rd(1'b1, 8'h02, 32'h0000060A, 1'b0);
    wr(1'b1, 8'h01, 32'hFFFFFFFF, 1'b1);
    rd(1'b1, 8'h01, 32'h20040700, 1'b0);
    rd(1'b1, 8'h03, 32'h00000000, 1'b1);
  endtask : t_desc

  task automatic t_perm();
    wr(1'b0, 8'h20, 32'h00001111, 1'b0);
    wr(1'b1, 8'h04, 32'hFFFFFFFF, 1'b0);
    rd(1'b1, 8'h04, 32'h00000001, 1'b0);
    wr(1'b1, 8'h20, 32'h0000AAAA, 1'b1);
    wr(1'b1, 8'h05, 32'h00000001, 1'b1);
    rd(1'b1, 8'h05, 32'h00000000, 1'b0);
    wr(1'b1, 8'h06, 32'h00000005, 1'b1);
    rd(1'b1, 8'h06, 32'h00000000, 1'b0);
    rd(1'b0, 8'h20, 32'h00001111, 1'b0);
    wr(1'b0, 8'h21, 32'h00002222, 1'b0);
    rd(1'b1, 8'h21, 32'h00002222, 1'b0);
    wr(1'b1, 8'h04, 32'h00000000, 1'b0);
    wr(1'b1, 8'h20, 32'h00003333, 1'b0);
    rd(1'b0, 8'h20, 32'h00003333, 1'b0);
  endtask : t_perm

  task automatic t_watch();
    wr(1'b0, 8'h50, 32'h00000100, 1'b0);
    wr(1'b0, 8'h60, 32'h00000200, 1'b0);
    wr(1'b0, 8'h70, 32'h00020005, 1'b0);
    op(1'b0, 1'b1, 3'h1, 32'h00000150, 1'b1, 3'h4, 2'h0);
    op(1'b0, 1'b1, 3'h2, 32'h00000150, 1'b0, 3'h0, 2'h0);
    op(1'b0, 1'b0, 3'h1, 32'h00000150, 1'b0, 3'h0, 2'h0);
    op(1'b0, 1'b1, 3'h1, 32'h00000300, 1'b0, 3'h0, 2'h0);
    wr(1'b0, 8'h70, 32'h00020007, 1'b0);
    op(1'b0, 1'b1, 3'h1, 32'h00000300, 1'b1, 3'h4, 2'h0);
    wr(1'b0, 8'h70, 32'h00020006, 1'b0);
    op(1'b0, 1'b1, 3'h1, 32'h00000150, 1'b0, 3'h0, 2'h0);
    wr(1'b0, 8'h81, 32'h000000FF, 1'b0);
    wr(1'b0, 8'h91, 32'h00000012, 1'b0);
    wr(1'b0, 8'h9D, 32'h00010001, 1'b0);
    op(1'b1, 1'b0, 3'h0, 32'h00001234, 1'b0, 3'h0, 2'h0);
    op(1'b1, 1'b0, 3'h0, 32'h00003312, 1'b1, 3'h5, 2'h1);
    wr(1'b0, 8'h9D, 32'h00010003, 1'b0);
    op(1'b1, 1'b0, 3'h0, 32'h00001234, 1'b1, 3'h5, 2'h1);
    wr(1'b0, 8'h70, 32'h00000000, 1'b0);
    wr(1'b0, 8'h9D, 32'h00000000, 1'b0);
  endtask : t_watch

  task automatic t_dbg();
    wr(1'b1, 8'h05, 32'hFFFFFFFF, 1'b0);
    rd(1'b1, 8'h05, 32'h00000001, 1'b0);
    `CHK("irq_req", 1'b1, dbg_irq_r)
    in_debug_mode = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("irq_dbgm", 1'b0, dbg_irq_r)
    rd(1'b1, 8'h05, 32'h00000002, 1'b0);
    in_debug_mode = 1'b0;
    rd(1'b1, 8'h05, 32'h00000000, 1'b0);
  endtask : t_dbg

  task automatic t_clk();
    int cnt;
    wr(1'b1, 8'h06, 32'hFFFFFFFF, 1'b0);
    rd(1'b1, 8'h06, 32'h8000FFFF, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(1'b1, 8'h06, k ? 32'h80000002 : 32'h00000002, 1'b0);
      repeat (2) @(negedge clk);
      cnt = 0;
      // Any nine consecutive cycles hold exactly three ticks at period three
      repeat (9) begin
        @(negedge clk);
        if (tile_tick_r === 1'b1) cnt++;
      end
      `CHK("ticks", k ? 0 : 3, cnt)
    end
    wr(1'b1, 8'h06, 32'h00000000, 1'b0);
  endtask : t_clk

  task automatic t_sec();
    logic [31:0] w[2];
    logic [8:0]  e[2];
    logic [8:0]  so;
    w = '{32'hFFFFFFFF, 32'h00000500};
    e = '{9'h1FF, 9'h005};
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      otp_sec_word = w[k];
      otp_sec_load = 1'b1;
      @(negedge clk);
      otp_sec_load = 1'b0;
      rd(1'b1, 8'h07, w[k] & 32'h80005FB1, 1'b0);
      so = {tap_deny_r, pll_boot_deny_r, boot_from_otp_r, otp_redundant_r,
            global_debug_deny_r, otp_sector_lock_r};
      `CHK("sec_out", e[k], so)
    end
    wr(1'b1, 8'h07, 32'hFFFFFFFF, 1'b1);
    rd(1'b1, 8'h07, 32'h00000500, 1'b0);
  endtask : t_sec

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    cfg_req = '0;
    mem_op = '0;
    res_op = '0;
    in_debug_mode = 1'b0;
    otp_sec_load = 1'b0;
    otp_sec_word = 32'h00000000;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_desc();
    t_perm();
    t_watch();
    t_dbg();
    t_clk();
    t_sec();
    end_of_test();
  end

  // Whole run is a few hundred cycles; this only cuts a hang short
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb
